// ---- logic/pin_route_pkg.sv ----
// Constants for timer channel routing and port S pin multiplexing
// Function
// (RULE_01) Routing bits 7:6 send timer0 channel7 to T7, R1, V6; code 11 gives T7.
// (RULE_02) Routing bit 5 sends timer0 channel5 to T5 when clear, V2 when set.
// (RULE_03) Routing bit 4 sends timer0 channel4 to T4 when clear, V0 when set.
// (RULE_04) Routing bits 3:2 send timer0 channel6 to T6, R0, V4; code 11 gives T6.
// (RULE_05) Routing bit 1 sends timer1 channel7 to T3 when clear, R3 when set.
// (RULE_06) Routing bit 0 sends timer1 channel6 to T2 when clear, R2 when set.
// (RULE_07) An unclaimed port S pin set as output drives its stored data bit.
// (RULE_08) Data read gives stored bit when direction is 1, else synchronised pin level.
// (RULE_09) On the slave-select pin an enabled SPI wins over two-wire, PWM_CHANNEL_3 and GPIO.
// (RULE_10) Without SPI, an enabled two-wire module wins that pin over PWM_CHANNEL_3 and GPIO.
// (RULE_11) Without either serial module, enabled PWM_CHANNEL_3 wins that pin over GPIO.
// (RULE_12) On the serial-clock pin an enabled SPI wins over PWM_CHANNEL_2 and GPIO.
// (RULE_13) Without SPI, enabled PWM_CHANNEL_2 wins the serial-clock pin over GPIO.
// (RULE_14) The reserved location always reads 0x00 and ignores writes.
// (RULE_15) A direction change may take two clocks to show in data reads.
// (RULE_16) A routing change moves the channel next clock and frees the old pin.
package pin_route_pkg;

  // Register byte addresses
  localparam logic [7:0] OFS_ROUTING  = 8'h00;
  localparam logic [7:0] OFS_PS_DATA  = 8'h04;
  localparam logic [7:0] OFS_PS_DIR   = 8'h08;
  localparam logic [7:0] OFS_RESERVED = 8'h0C;

  // Reset values
  localparam logic [7:0] RST_ROUTING = 8'h00;
  localparam logic [7:0] RST_PS_DATA = 8'h00;
  localparam logic [7:0] RST_PS_DIR  = 8'h00;
  localparam logic [7:0] RSV_READ    = 8'h00;

  // Routing field positions
  localparam int F_T0C7_LO = 6;
  localparam int F_T0C5    = 5;
  localparam int F_T0C4    = 4;
  localparam int F_T0C6_LO = 2;
  localparam int F_T1C7    = 1;
  localparam int F_T1C6    = 0;

  // Two-bit routing codes
  localparam logic [1:0] SEL_T   = 2'h0;
  localparam logic [1:0] SEL_R   = 2'h1;
  localparam logic [1:0] SEL_V   = 2'h2;
  localparam logic [1:0] SEL_RSV = 2'h3;

  // Timer channel indices
  localparam int NCH            = 6;
  localparam int timer0_channel7 = 0;
  localparam int timer0_channel6 = 1;
  localparam int timer0_channel5 = 2;
  localparam int timer0_channel4 = 3;
  localparam int timer1_channel7 = 4;
  localparam int timer1_channel6 = 5;

  // Routed pin indices
  localparam int NPIN        = 14;
  localparam int port_t_pin7 = 0;
  localparam int port_t_pin6 = 1;
  localparam int port_t_pin5 = 2;
  localparam int port_t_pin4 = 3;
  localparam int port_t_pin3 = 4;
  localparam int port_t_pin2 = 5;
  localparam int port_r_pin0 = 6;
  localparam int port_r_pin1 = 7;
  localparam int port_r_pin2 = 8;
  localparam int port_r_pin3 = 9;
  localparam int port_v_pin0 = 10;
  localparam int port_v_pin2 = 11;
  localparam int port_v_pin4 = 12;
  localparam int port_v_pin6 = 13;

  // Port S shared pin positions
  localparam int PS_SS_BIT  = 3;
  localparam int PS_SCK_BIT = 2;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

endpackage

// ---- logic/pin_sync.sv ----
// Two-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // Asynchronous level in, synchronised level out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_reg;

  // First stage feeds only the second stage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule // pin_sync

// ---- logic/timer_channel_routing_and_port_s.sv ----
// Timer channel pin routing and port S pin multiplexing behind an AXI4-Lite slave
`timescale 1ns/1ps
module timer_channel_routing_and_port_s (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  // AXI4-Lite write data
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  // AXI4-Lite write response
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // AXI4-Lite read address
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  // AXI4-Lite read data
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // Timer channels, index order from the package
  input  wire logic [5:0]  tim_ch_out,
  input  wire logic [5:0]  tim_ch_oe,
  output logic [5:0]       tim_ch_in,
  // Routed timer pins
  input  wire logic [13:0] route_pin_in,
  output logic [13:0]      route_pin_out,
  output logic [13:0]      route_pin_oe_n,
  // Serial and PWM peripherals on port S
  input  wire logic        spi_en,
  input  wire logic        spi_ss_out,
  input  wire logic        spi_ss_oe,
  input  wire logic        spi_sck_out,
  input  wire logic        spi_sck_oe,
  input  wire logic        iic_en,
  input  wire logic        iic_sda_out,
  input  wire logic        iic_sda_oe,
  input  wire logic        pwm_channel_3_en,
  input  wire logic        pwm_channel_3_out,
  input  wire logic        pwm_channel_2_en,
  input  wire logic        pwm_channel_2_out,
  // Port S pins
  input  wire logic [7:0]  ps_pin_in,
  output logic [7:0]       ps_pin_out,
  output logic [7:0]       ps_pin_oe_n,
  output logic [7:0]       ps_pin_level
);

  // Registers
  logic [7:0] routing_reg;
  logic [7:0] ps_data_reg;
  logic [7:0] ps_dir_reg;

  // Write channel state
  logic       aw_held_reg;
  logic [7:0] aw_addr_reg;
  logic       w_held_reg;
  logic [7:0] w_data_reg;
  logic       w_strb_reg;
  logic       bvalid_reg;
  logic [1:0] bresp_reg;

  // Read channel state
  logic        rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0]  rresp_reg;

  // Synchronised pins
  logic [7:0]  ps_sync;
  logic [13:0] route_sync;

  // Synchronisers add two clocks of latency on input reads
  pin_sync #(.W(8)) u_ps_sync (  // RULE_15
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       (ps_pin_in),
    .q       (ps_sync)
  );

  pin_sync #(.W(14)) u_route_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       (route_pin_in),
    .q       (route_sync)
  );

  // Write path: address and data may arrive in either order
  wire        aw_take = awvalid && awready;
  wire        w_take  = wvalid && wready;
  wire        aw_have = aw_held_reg || aw_take;
  wire        w_have  = w_held_reg || w_take;
  wire        do_wr   = aw_have && w_have && !bvalid_reg;
  wire [7:0]  wr_addr = aw_held_reg ? aw_addr_reg : awaddr;
  wire [7:0]  wr_data = w_held_reg ? w_data_reg : wdata[7:0];
  wire        wr_lane = w_held_reg ? w_strb_reg : wstrb[0];
  wire        wr_en   = do_wr && wr_lane;
  wire        wr_rout = wr_en && (wr_addr == pin_route_pkg::OFS_ROUTING);
  wire        wr_data_hit = wr_en && (wr_addr == pin_route_pkg::OFS_PS_DATA);
  wire        wr_dir  = wr_en && (wr_addr == pin_route_pkg::OFS_PS_DIR);
  wire        wr_map  = (wr_addr == pin_route_pkg::OFS_ROUTING) ||
                        (wr_addr == pin_route_pkg::OFS_PS_DATA) ||
                        (wr_addr == pin_route_pkg::OFS_PS_DIR) ||
                        (wr_addr == pin_route_pkg::OFS_RESERVED);

  assign awready = !aw_held_reg && !bvalid_reg;
  assign wready  = !w_held_reg && !bvalid_reg;
  assign bvalid  = bvalid_reg;
  assign bresp   = bresp_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg  <= 8'h00;
      w_strb_reg  <= 1'b0;
    end else begin
      aw_held_reg <= aw_have && !do_wr;
      w_held_reg  <= w_have && !do_wr;
      if (aw_take) begin
        aw_addr_reg <= awaddr;
      end
      if (w_take) begin
        w_data_reg <= wdata[7:0];
        w_strb_reg <= wstrb[0];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= pin_route_pkg::RESP_OKAY;
    end else if (do_wr) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= wr_map ? pin_route_pkg::RESP_OKAY : pin_route_pkg::RESP_DECERR;
    end else if (bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // Reserved location has no storage, so writes there fall away
  always_ff @(posedge aclk) begin  // RULE_14
    if (!aresetn) begin
      routing_reg <= pin_route_pkg::RST_ROUTING;
      ps_data_reg <= pin_route_pkg::RST_PS_DATA;
      ps_dir_reg  <= pin_route_pkg::RST_PS_DIR;
    end else begin
      if (wr_rout) begin
        routing_reg <= wr_data;
      end
      if (wr_data_hit) begin
        ps_data_reg <= wr_data;
      end
      if (wr_dir) begin
        ps_dir_reg <= wr_data;
      end
    end
  end

  // Read path
  wire       ar_take = arvalid && arready;
  wire [7:0] ps_read = (ps_dir_reg & ps_data_reg) | (~ps_dir_reg & ps_sync);  // RULE_08
  wire       rd_map  = (araddr == pin_route_pkg::OFS_ROUTING) ||
                       (araddr == pin_route_pkg::OFS_PS_DATA) ||
                       (araddr == pin_route_pkg::OFS_PS_DIR) ||
                       (araddr == pin_route_pkg::OFS_RESERVED);
  wire [7:0] rd_byte =
    (araddr == pin_route_pkg::OFS_ROUTING) ? routing_reg :
    (araddr == pin_route_pkg::OFS_PS_DATA) ? ps_read :
    (araddr == pin_route_pkg::OFS_PS_DIR)  ? ps_dir_reg :
    pin_route_pkg::RSV_READ;  // RULE_14

  assign arready = !rvalid_reg;
  assign rvalid  = rvalid_reg;
  assign rdata   = rdata_reg;
  assign rresp   = rresp_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      rresp_reg  <= pin_route_pkg::RESP_OKAY;
    end else if (ar_take) begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= {24'h00_0000, rd_byte};
      rresp_reg  <= rd_map ? pin_route_pkg::RESP_OKAY : pin_route_pkg::RESP_DECERR;
    end else if (rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // Routing decode, one-hot pin choice per channel
  wire [1:0] c7_code = routing_reg[pin_route_pkg::F_T0C7_LO +: 2];
  wire [1:0] c6_code = routing_reg[pin_route_pkg::F_T0C6_LO +: 2];
  logic [13:0] ch_sel [6];

  assign ch_sel[pin_route_pkg::timer0_channel7] =  // RULE_01
    (c7_code == pin_route_pkg::SEL_R) ? 14'(1) << pin_route_pkg::port_r_pin1 :
    (c7_code == pin_route_pkg::SEL_V) ? 14'(1) << pin_route_pkg::port_v_pin6 :
    14'(1) << pin_route_pkg::port_t_pin7;
  assign ch_sel[pin_route_pkg::timer0_channel6] =  // RULE_04
    (c6_code == pin_route_pkg::SEL_R) ? 14'(1) << pin_route_pkg::port_r_pin0 :
    (c6_code == pin_route_pkg::SEL_V) ? 14'(1) << pin_route_pkg::port_v_pin4 :
    14'(1) << pin_route_pkg::port_t_pin6;
  assign ch_sel[pin_route_pkg::timer0_channel5] = routing_reg[pin_route_pkg::F_T0C5] ?  // RULE_02
    14'(1) << pin_route_pkg::port_v_pin2 : 14'(1) << pin_route_pkg::port_t_pin5;
  assign ch_sel[pin_route_pkg::timer0_channel4] = routing_reg[pin_route_pkg::F_T0C4] ?  // RULE_03
    14'(1) << pin_route_pkg::port_v_pin0 : 14'(1) << pin_route_pkg::port_t_pin4;
  assign ch_sel[pin_route_pkg::timer1_channel7] = routing_reg[pin_route_pkg::F_T1C7] ?  // RULE_05
    14'(1) << pin_route_pkg::port_r_pin3 : 14'(1) << pin_route_pkg::port_t_pin3;
  assign ch_sel[pin_route_pkg::timer1_channel6] = routing_reg[pin_route_pkg::F_T1C6] ?  // RULE_06
    14'(1) << pin_route_pkg::port_r_pin2 : 14'(1) << pin_route_pkg::port_t_pin2;

  // Each pin is claimed by at most one channel, so OR-ing is safe
  logic [13:0] pin_drv_next;
  logic [13:0] pin_val_next;
  logic [5:0]  ch_in_next;

  genvar gp;
  generate
    for (gp = 0; gp < pin_route_pkg::NPIN; gp++) begin : g_pin
      logic [5:0] hit;
      for (genvar gc = 0; gc < pin_route_pkg::NCH; gc++) begin : g_ch
        assign hit[gc] = ch_sel[gc][gp];
      end
      assign pin_drv_next[gp] = |(hit & tim_ch_oe);
      assign pin_val_next[gp] = |(hit & tim_ch_oe & tim_ch_out);
    end
    for (gp = 0; gp < pin_route_pkg::NCH; gp++) begin : g_cap
      assign ch_in_next[gp] = |(ch_sel[gp] & route_sync);
    end
  endgenerate

  // Unselected pins drop their enable on the clock after a change
  always_ff @(posedge aclk) begin  // RULE_16
    if (!aresetn) begin
      route_pin_out  <= 14'h0000;
      route_pin_oe_n <= 14'h3FFF;
      tim_ch_in      <= 6'h00;
    end else begin
      route_pin_out  <= pin_val_next;
      route_pin_oe_n <= ~pin_drv_next;
      tim_ch_in      <= ch_in_next;
    end
  end

  // Slave-select pin ownership
  wire ss_spi  = spi_en;  // RULE_09
  wire ss_iic  = !spi_en && iic_en;  // RULE_10
  wire ss_pwm  = !spi_en && !iic_en && pwm_channel_3_en;  // RULE_11
  wire ss_drv  = ss_spi ? spi_ss_oe : ss_iic ? iic_sda_oe : ss_pwm ? 1'b1 :
                 ps_dir_reg[pin_route_pkg::PS_SS_BIT];
  wire ss_val  = ss_spi ? spi_ss_out : ss_iic ? iic_sda_out : ss_pwm ? pwm_channel_3_out :
                 ps_data_reg[pin_route_pkg::PS_SS_BIT];

  // Serial-clock pin ownership
  wire sck_spi = spi_en;  // RULE_12
  wire sck_pwm = !spi_en && pwm_channel_2_en;  // RULE_13
  wire sck_drv = sck_spi ? spi_sck_oe : sck_pwm ? 1'b1 :
                 ps_dir_reg[pin_route_pkg::PS_SCK_BIT];
  wire sck_val = sck_spi ? spi_sck_out : sck_pwm ? pwm_channel_2_out :
                 ps_data_reg[pin_route_pkg::PS_SCK_BIT];

  logic [7:0] ps_drv_next;
  logic [7:0] ps_val_next;

  generate
    for (gp = 0; gp < 8; gp++) begin : g_ps
      if (gp == pin_route_pkg::PS_SS_BIT) begin : g_ss
        assign ps_drv_next[gp] = ss_drv;
        assign ps_val_next[gp] = ss_val;
      end else if (gp == pin_route_pkg::PS_SCK_BIT) begin : g_sck
        assign ps_drv_next[gp] = sck_drv;
        assign ps_val_next[gp] = sck_val;
      end else begin : g_gpio
        assign ps_drv_next[gp] = ps_dir_reg[gp];  // RULE_07
        assign ps_val_next[gp] = ps_data_reg[gp];
      end
    end
  endgenerate

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ps_pin_out   <= 8'h00;
      ps_pin_oe_n  <= 8'hFF;
      ps_pin_level <= 8'h00;
    end else begin
      ps_pin_out   <= ps_val_next;
      ps_pin_oe_n  <= ~ps_drv_next;
      ps_pin_level <= ps_sync;
    end
  end

  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_wr_routing;
    wr_rout;
  endsequence

  sequence s_ch7_on_r;
    (routing_reg[7:6] == 2'h1) && tim_ch_oe[0];
  endsequence

  chk_ch7_route_r: assert property (s_ch7_on_r |=> !route_pin_oe_n[7] && route_pin_out[7] == $past(tim_ch_out[0]))  // RULE_01
    else $error("channel7 not on port R pin1");
  chk_ch7_reserved: assert property ((routing_reg[7:6] == 2'h3) && tim_ch_oe[0] |=> !route_pin_oe_n[0])  // RULE_01
    else $error("reserved code not on port T pin7");
  chk_ch5_route_v: assert property (routing_reg[5] && tim_ch_oe[2] |=> !route_pin_oe_n[11] && route_pin_oe_n[2])  // RULE_02
    else $error("channel5 routing wrong");
  chk_ch4_route_v: assert property (routing_reg[4] && tim_ch_oe[3] |=> !route_pin_oe_n[10] && route_pin_oe_n[3])  // RULE_03
    else $error("channel4 routing wrong");
  chk_ch6_route_v: assert property ((routing_reg[3:2] == 2'h2) && tim_ch_oe[1] |=> !route_pin_oe_n[12])  // RULE_04
    else $error("channel6 not on port V pin4");
  chk_t1c7_route: assert property (!routing_reg[1] && tim_ch_oe[4] |=> !route_pin_oe_n[4] && route_pin_oe_n[9])  // RULE_05
    else $error("timer1 channel7 routing wrong");
  chk_t1c6_route: assert property (routing_reg[0] && tim_ch_oe[5] |=> !route_pin_oe_n[8] && route_pin_oe_n[5])  // RULE_06
    else $error("timer1 channel6 routing wrong");
  chk_route_release: assert property (s_wr_routing ##1 (routing_reg[7:6] != 2'h1) |=> route_pin_oe_n[7])  // RULE_16
    else $error("old pin still driven after rerouting");
  chk_gpio_drive: assert property (ps_dir_reg[0] |=> !ps_pin_oe_n[0] && ps_pin_out[0] == $past(ps_data_reg[0]))  // RULE_07
    else $error("GPIO output not driven");
  chk_read_source: assert property (ar_take && araddr == 8'h04 |=> rvalid && rdata[7:0] == $past(ps_read))  // RULE_08
    else $error("data read from wrong source");
  chk_ss_spi_owns: assert property (spi_en && spi_ss_oe |=> ps_pin_out[3] == $past(spi_ss_out) && !ps_pin_oe_n[3])  // RULE_09
    else $error("SPI lost slave-select pin");
  chk_ss_iic_owns: assert property (!spi_en && iic_en |=> ps_pin_oe_n[3] == !$past(iic_sda_oe))  // RULE_10
    else $error("two-wire lost data pin");
  chk_ss_pwm_owns: assert property (!spi_en && !iic_en && pwm_channel_3_en |=> ps_pin_out[3] == $past(pwm_channel_3_out))  // RULE_11
    else $error("PWM_CHANNEL_3 lost shared pin");
  chk_sck_spi_owns: assert property (spi_en |=> ps_pin_oe_n[2] == !$past(spi_sck_oe))  // RULE_12
    else $error("SPI lost clock pin");
  chk_sck_pwm_owns: assert property (!spi_en && pwm_channel_2_en |=> !ps_pin_oe_n[2] && ps_pin_out[2] == $past(pwm_channel_2_out))  // RULE_13
    else $error("PWM_CHANNEL_2 lost clock pin");
  chk_rsv_reads_zero: assert property (ar_take && araddr == 8'h0C |=> rdata == 32'h0000_0000 && rresp == 2'h0)  // RULE_14
    else $error("reserved location not zero");
  // The synchroniser holds reset zeros for two clocks after release, so those cycles are left out
  chk_dir_settle: assert property (!ps_dir_reg[1] [*3] ##0 $past(aresetn, 2) |->  // RULE_15
    ps_read[1] == $past(ps_pin_in[1], 2))
    else $error("input read not settled in two clocks");
  chk_bresp_follow: assert property (do_wr |=> bvalid)
    else $error("write response missing");

endmodule // timer_channel_routing_and_port_s

// ---- sim/pin_partner.sv ----
// Pin-side model: resolves the level of every routed and port S pin
`timescale 1ns/1ps
module pin_partner #(
  parameter int DLY = 1
) (
  // Routed timer pins
  input  wire logic [13:0] route_pin_out,
  input  wire logic [13:0] route_pin_oe_n,
  output logic      [13:0] route_pin_in,
  // Port S pins
  input  wire logic [7:0]  ps_pin_out,
  input  wire logic [7:0]  ps_pin_oe_n,
  output logic      [7:0]  ps_pin_in
);
  // Released pins sit on a pull-up, so a stale driven value never lingers
  // The delay stands in for slow pad settling against the synchronisers
  assign #DLY route_pin_in = route_pin_out | route_pin_oe_n;
  assign #DLY ps_pin_in    = ps_pin_out | ps_pin_oe_n;
endmodule // pin_partner

// ---- sim/test_timer_channel_routing_and_port_s.sv ----
// Self-checking bench for timer channel routing and port S multiplexing
`timescale 1ns/1ps
module test_timer_channel_routing_and_port_s;
  typedef struct packed {logic [7:0] r; logic [13:0] m;} route_row_t;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h00000000;
  logic [3:0]  wstrb = 4'h0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [5:0]  tim_ch_out = 6'h00, tim_ch_oe = 6'h00, tim_ch_in;
  logic [13:0] route_pin_in, route_pin_out, route_pin_oe_n;
  logic        spi_en = 1'b0, spi_ss_out = 1'b0, spi_ss_oe = 1'b1, spi_sck_out = 1'b0, spi_sck_oe = 1'b1;
  logic        iic_en = 1'b0, iic_sda_out = 1'b0, iic_sda_oe = 1'b0;
  logic        pwm_channel_3_en = 1'b0, pwm_channel_3_out = 1'b1, pwm_channel_2_en = 1'b0, pwm_channel_2_out = 1'b1;
  logic [7:0]  ps_pin_in, ps_pin_out, ps_pin_oe_n, ps_pin_level, q, eoe, eout;
  logic [1:0]  r;
  int          fail_count = 0, check_count = 0;
  // Drive masks worked out by hand from the routing codes (pin index order)
  route_row_t  rows [4] = '{'{8'h00, 14'h003F}, '{8'h55, 14'h05D4}, '{8'hAA, 14'h3A28}, '{8'hFF, 14'h0F03}};

  always #2.5 aclk = ~aclk;

  timer_channel_routing_and_port_s i_dut (
    .aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .tim_ch_out(tim_ch_out), .tim_ch_oe(tim_ch_oe), .tim_ch_in(tim_ch_in),
    .route_pin_in(route_pin_in), .route_pin_out(route_pin_out), .route_pin_oe_n(route_pin_oe_n),
    .spi_en(spi_en), .spi_ss_out(spi_ss_out), .spi_ss_oe(spi_ss_oe),
    .spi_sck_out(spi_sck_out), .spi_sck_oe(spi_sck_oe),
    .iic_en(iic_en), .iic_sda_out(iic_sda_out), .iic_sda_oe(iic_sda_oe),
    .pwm_channel_3_en(pwm_channel_3_en), .pwm_channel_3_out(pwm_channel_3_out), .pwm_channel_2_en(pwm_channel_2_en), .pwm_channel_2_out(pwm_channel_2_out),
    .ps_pin_in(ps_pin_in), .ps_pin_out(ps_pin_out), .ps_pin_oe_n(ps_pin_oe_n), .ps_pin_level(ps_pin_level)
  );

  pin_partner i_pins (
    .route_pin_out(route_pin_out), .route_pin_oe_n(route_pin_oe_n), .route_pin_in(route_pin_in),
    .ps_pin_out(ps_pin_out), .ps_pin_oe_n(ps_pin_oe_n), .ps_pin_in(ps_pin_in)
  );

  task automatic close_out();
    if (fail_count == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // A request goes up after an edge and stands until its ready is sampled high at a rising edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [3:0] s,
                      output logic [7:0] rq, output logic [1:0] rs);
    logic dn;
    int   n;
    rq = 8'h00;
    rs = 2'h0;
    dn = 1'b0;
    @(posedge aclk);
    if (w) begin
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= {24'h000000, d};
      wstrb <= s;
      wvalid <= 1'b1;
      bready <= 1'b1;
    end else begin
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
    end
    for (n = 0; n < 40 && !dn; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (arvalid && arready) arvalid <= 1'b0;
      dn = w ? bvalid : rvalid;
      if (dn) begin
        rs = w ? bresp : rresp;
        rq = rdata[7:0];
        bready <= 1'b0;
        rready <= 1'b0;
      end
    end
    if (!dn) begin
      fail_count++;
      close_out();
    end
  endtask

  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    check("ps_oe_n_rst", ps_pin_oe_n, 8'hFF);
    check("route_oe_n_rst", route_pin_oe_n, 14'h3FFF);
    xfer(1'b0, pin_route_pkg::OFS_ROUTING, 8'h00, 4'h0, q, r);
    check("routing_rst", q, pin_route_pkg::RST_ROUTING);
    xfer(1'b0, pin_route_pkg::OFS_PS_DIR, 8'h00, 4'h0, q, r);
    check("dir_rst", q, pin_route_pkg::RST_PS_DIR);
    tim_ch_oe <= 6'h3F;
    foreach (rows[i]) begin
      xfer(1'b1, pin_route_pkg::OFS_ROUTING, rows[i].r, 4'h1, q, r);
      xfer(1'b0, pin_route_pkg::OFS_ROUTING, 8'h00, 4'h0, q, r);
      check("route_oe_n", route_pin_oe_n, 14'(~rows[i].m));
      check("route_rd", q, rows[i].r);
      check("route_rresp", r, pin_route_pkg::RESP_OKAY);
      for (int v = 0; v < 2; v++) begin
        tim_ch_out <= {6{v[0]}};
        repeat (6) @(posedge aclk);
        check("route_out", route_pin_out & rows[i].m, v[0] ? rows[i].m : 14'h0000);
        check("tim_in", tim_ch_in, {6{v[0]}});
      end
    end
    // Precedence on the shared port S pins, two passes so every owner has its own signature
    xfer(1'b1, pin_route_pkg::OFS_PS_DIR, 8'hFF, 4'h1, q, r);
    for (int p = 0; p < 2; p++) begin
      xfer(1'b1, pin_route_pkg::OFS_PS_DATA, p[0] ? 8'h00 : 8'hFF, 4'h1, q, r);
      spi_ss_out <= p[0];
      spi_sck_out <= p[0];
      for (int i = 0; i < 16; i++) begin
        {spi_en, iic_en, pwm_channel_3_en, pwm_channel_2_en} <= i[3:0];
        repeat (4) @(posedge aclk);
        eoe = 8'h00;
        eout = {8{~p[0]}};
        if (i[3]) eout[3] = p[0];
        else if (i[2]) eoe[3] = 1'b1;
        else if (i[1]) eout[3] = 1'b1;
        if (i[3]) eout[2] = p[0];
        else if (i[0]) eout[2] = 1'b1;
        check("ps_oe_n", ps_pin_oe_n, eoe);
        check("ps_out", ps_pin_out & ~eoe, eout & ~eoe);
      end
    end
    // Data reads: pin level when input, stored bit when output even on a released pin
    {spi_en, iic_en, pwm_channel_3_en, pwm_channel_2_en} <= 4'h4;
    xfer(1'b1, pin_route_pkg::OFS_PS_DATA, 8'h00, 4'h1, q, r);
    xfer(1'b1, pin_route_pkg::OFS_PS_DIR, 8'h00, 4'h1, q, r);
    repeat (2) @(posedge aclk);
    xfer(1'b0, pin_route_pkg::OFS_PS_DATA, 8'h00, 4'h0, q, r);
    check("ps_rd_in", q, 8'hFF);
    xfer(1'b1, pin_route_pkg::OFS_PS_DIR, 8'hFF, 4'h1, q, r);
    repeat (2) @(posedge aclk);
    xfer(1'b0, pin_route_pkg::OFS_PS_DATA, 8'h00, 4'h0, q, r);
    check("ps_rd_out", q, 8'h00);
    check("ps_level", ps_pin_level, 8'h08);
    iic_sda_oe <= 1'b1;
    iic_sda_out <= 1'b1;
    repeat (4) @(posedge aclk);
    check("ps_iic_drv", {ps_pin_oe_n, ps_pin_out}, 16'h0008);
    // Reserved place, unmapped address and a write with its byte strobe off
    xfer(1'b1, pin_route_pkg::OFS_RESERVED, 8'hFF, 4'h1, q, r);
    check("rsv_bresp", r, pin_route_pkg::RESP_OKAY);
    xfer(1'b0, pin_route_pkg::OFS_RESERVED, 8'h00, 4'h0, q, r);
    check("rsv_rd", q, pin_route_pkg::RSV_READ);
    xfer(1'b1, 8'h10, 8'hFF, 4'h1, q, r);
    check("unm_bresp", r, pin_route_pkg::RESP_DECERR);
    xfer(1'b0, 8'h10, 8'h00, 4'h0, q, r);
    check("unm_rresp", r, pin_route_pkg::RESP_DECERR);
    check("unm_rd", q, 8'h00);
    xfer(1'b1, pin_route_pkg::OFS_ROUTING, 8'h33, 4'h0, q, r);
    xfer(1'b0, pin_route_pkg::OFS_ROUTING, 8'h00, 4'h0, q, r);
    check("strb_off", q, 8'hFF);
    close_out();
  end
endmodule // test_timer_channel_routing_and_port_s
